// [rtl/dssfl_top.sv]
/*
 drive-side start handshake on clk/dat and the fast synchronous serial link
 (srq clock, data line) with byte send and receive re-arming.
 assumes open-drain bus lines resolved outside; bus inputs are asynchronous.
*/
// Operation
// RL1: host allows variable start latency
// RL2: drive pulls clk low, releases dat
// RL3: wait dat low, release clk, wait high
// RL4: host pulses dat low after clk low
// RL5: start signal given on clk only
// RL6: host ignores early dat low
// RL7: host accepts bus-type supersets
// RL8: version code separate from bus type
// RL9: fast support shown in version number; code passes VERSION_CODE through, bit 7 not set from bus type
// RL10: test fast link with one byte
// RL11: receiver stays bit aligned with sender
// RL12: send re-arms receiver for eight bits
// RL13: receive enable always reinitialises receiver
// RL14: enable once, sends re-arm automatically
// RL15: host assumes nothing of os routines
// RL16: handshake waits forever, no timeout
`timescale 1ns/1ps
`include "dssfl_defines.svh"
module dssfl_top #(
  parameter logic [7:0] VERSION_CODE = 8'h81,
  parameter logic [3:0] BUS_TYPE = `DSSFL_BUS_FAST,
  parameter int HALF_BIT = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // program operations
  input wire logic clk_low_dat_release_op,
  input wire logic wait_dat_low_op,
  input wire logic clk_release_op,
  input wire logic wait_dat_high_op,
  input wire logic fast_link_send_byte,
  input wire logic [7:0] send_data,
  input wire logic fast_link_receive_enable,
  output logic op_busy,
  output logic sync_done,
  // identity
  output logic [7:0] version_code,
  output logic [3:0] bus_type,
  // serial bus lines
  input wire logic clk_in,
  output logic clk_out,
  output logic clk_oe,
  input wire logic dat_in,
  output logic dat_out,
  output logic dat_oe,
  input wire logic srq_in,
  output logic srq_out,
  output logic srq_oe,
  // fast link receive
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_armed
);
  logic [1:0] clk_s_ff, dat_s_ff, srq_s_ff;
  logic srq_prev_ff;
  logic clk_drive_ff, dat_drive_ff;
  dssfl_pkg::dssfl_sync_t state_ff;
  logic [3:0] tx_cnt_ff, rx_cnt_ff;
  logic [7:0] tx_sh_ff, rx_sh_ff, rx_data_ff;
  logic [7:0] half_ff;
  logic tx_clk_ff, tx_act_ff, rx_valid_ff, rx_arm_ff;
  logic dat_s, clk_s, srq_s, srq_rise, rx_init;

  // two-stage synchronisers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_s_ff <= 2'h3;
      dat_s_ff <= 2'h3;
      srq_s_ff <= 2'h3;
      srq_prev_ff <= 1'b1;
    end else begin
      clk_s_ff <= {clk_s_ff[0], clk_in};
      dat_s_ff <= {dat_s_ff[0], dat_in};
      srq_s_ff <= {srq_s_ff[0], srq_in};
      srq_prev_ff <= srq_s_ff[1];
    end
  end
  assign clk_s = clk_s_ff[1];
  assign dat_s = dat_s_ff[1];
  assign srq_s = srq_s_ff[1];
  assign srq_rise = srq_s & ~srq_prev_ff;

  // start handshake
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= dssfl_pkg::DSSFL_IDLE;
      clk_drive_ff <= 1'b0;
      dat_drive_ff <= 1'b0;
    end else begin
      case (state_ff)
        dssfl_pkg::DSSFL_IDLE: begin
          // RL2: clk low dat released
          // RL5: signal on clk
          if (clk_low_dat_release_op) begin
            clk_drive_ff <= 1'b1;
            dat_drive_ff <= 1'b0;
          end
          if (wait_dat_low_op) begin
            state_ff <= dssfl_pkg::DSSFL_WAIT_LOW;
          end else if (clk_release_op) begin
            clk_drive_ff <= 1'b0;
          end else if (wait_dat_high_op) begin
            state_ff <= dssfl_pkg::DSSFL_WAIT_HIGH;
          end
        end
        // RL3: wait dat low
        // RL16: no timeout here
        dssfl_pkg::DSSFL_WAIT_LOW: begin
          if (!dat_s) begin
            state_ff <= dssfl_pkg::DSSFL_IDLE;
          end
        end
        // RL3: wait dat high
        dssfl_pkg::DSSFL_WAIT_HIGH: begin
          if (dat_s) begin
            state_ff <= dssfl_pkg::DSSFL_DONE;
          end
        end
        dssfl_pkg::DSSFL_DONE: begin
          state_ff <= dssfl_pkg::DSSFL_IDLE;
        end
        default: begin
          state_ff <= dssfl_pkg::DSSFL_IDLE;
        end
      endcase
    end
  end

  // fast link transmitter: msb first, srq driven low for the first half of each bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_act_ff <= 1'b0;
      tx_cnt_ff <= 4'h0;
      tx_sh_ff <= 8'h00;
      tx_clk_ff <= 1'b1;
      half_ff <= 8'h00;
    end else if (fast_link_send_byte && !tx_act_ff) begin
      // RL10: single test byte send
      tx_act_ff <= 1'b1;
      tx_cnt_ff <= `DSSFL_BITS;
      tx_sh_ff <= send_data;
      tx_clk_ff <= 1'b0;
      half_ff <= 8'h00;
    end else if (tx_act_ff) begin
      if (half_ff == 8'(HALF_BIT - 1)) begin
        half_ff <= 8'h00;
        tx_clk_ff <= ~tx_clk_ff;
        // RL11: data moves only as srq is pulled low
        if (tx_clk_ff) begin
          tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
          tx_cnt_ff <= 4'(tx_cnt_ff - 4'h1);
          if (tx_cnt_ff == 4'h1) begin
            tx_act_ff <= 1'b0;
          end
        end
      end else begin
        half_ff <= 8'(half_ff + 8'h01);
      end
    end
  end

  // RL12: send re-arms receiver
  // RL13: enable always reinitialises
  assign rx_init = fast_link_receive_enable | (fast_link_send_byte & ~tx_act_ff);

  // fast link receiver, sampled on rising srq
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_arm_ff <= 1'b0;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_data_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (rx_init) begin
        rx_arm_ff <= 1'b1;
        rx_cnt_ff <= 4'h0;
        rx_sh_ff <= 8'h00;
      end else if (rx_arm_ff && !tx_act_ff && srq_rise) begin
        // RL11: bits land in order
        rx_sh_ff <= {rx_sh_ff[6:0], dat_s};
        if (rx_cnt_ff == 4'(`DSSFL_BITS - 4'h1)) begin
          // RL14: stays armed for next byte
          rx_cnt_ff <= 4'h0;
          rx_data_ff <= {rx_sh_ff[6:0], dat_s};
          rx_valid_ff <= 1'b1;
        end else begin
          rx_cnt_ff <= 4'(rx_cnt_ff + 4'h1);
        end
      end
    end
  end

  assign op_busy = (state_ff == dssfl_pkg::DSSFL_WAIT_LOW) |
                   (state_ff == dssfl_pkg::DSSFL_WAIT_HIGH) | tx_act_ff;
  assign sync_done = (state_ff == dssfl_pkg::DSSFL_DONE);
  // RL8: version independent of bus type
  // RL9: version is VERSION_CODE as given, fast bit not derived from bus type
  assign version_code = VERSION_CODE;
  assign bus_type = BUS_TYPE;
  assign clk_out = 1'b0;
  assign clk_oe = clk_drive_ff;
  assign dat_out = tx_act_ff ? tx_sh_ff[7] : 1'b0;
  assign dat_oe = dat_drive_ff | (tx_act_ff & ~tx_sh_ff[7]);
  assign srq_out = 1'b0;
  assign srq_oe = tx_act_ff & ~tx_clk_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_armed = rx_arm_ff;
endmodule

// [common/dssfl_defines.svh]
/*
 defines for the drive start-sync and fast-link block: bus-type codes,
 fast-link framing and the version-code fast-support bit.
 assumes inclusion by bare name.
*/
`ifndef DSSFL_DEFINES_SVH
`define DSSFL_DEFINES_SVH
`define DSSFL_BUS_SERIAL 4'h2
`define DSSFL_BUS_FAST 4'h3
`define DSSFL_BUS_PAR 4'h4
`define DSSFL_BUS_FAST_PAR 4'h5
`define DSSFL_BITS 4'h8
`define DSSFL_VER_FAST_BIT 7
`endif

// [common/dssfl_pkg.sv]
/*
 types for the drive start-sync and fast-link block.
 assumes the defines header is compiled alongside.
*/
package dssfl_pkg;
  typedef enum logic [2:0] {
    DSSFL_IDLE,
    DSSFL_WAIT_LOW,
    DSSFL_WAIT_HIGH,
    DSSFL_DONE
  } dssfl_sync_t;
endpackage

// [test/dssfl_chk.sv]
/* assertions on the dssfl_top ports.
   bound to every dssfl_top instance by the bind at the foot. */
`timescale 1ns/1ps
module dssfl_chk #(
  parameter logic [7:0] VERSION_CODE = 8'h81,
  parameter logic [3:0] BUS_TYPE = 4'h3
) (
  input wire logic sys_clk, reset_n, clk_low_dat_release_op, wait_dat_low_op,
  input wire logic fast_link_send_byte, fast_link_receive_enable, dat_in,
  input wire logic [7:0] send_data, version_code,
  input wire logic [3:0] bus_type,
  input wire logic op_busy, sync_done, clk_oe, dat_oe, srq_oe, rx_armed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_send; fast_link_send_byte && !op_busy; endsequence
  sequence s_frame; op_busy[*8] ##[50:62] !op_busy; endsequence
  a_clk_low_taken: assert property (clk_low_dat_release_op && !op_busy && !sync_done |=> clk_oe)
    else $error("clk not pulled low");
  a_dat_left_free: assert property (!op_busy |-> !dat_oe)
    else $error("dat driven outside a transfer");
  a_wait_holds: assert property (wait_dat_low_op && !op_busy && dat_in && $past(dat_in)
    && $past(dat_in, 2) ##1 dat_in[*4] |-> op_busy)
    else $error("wait ended with dat high");
  a_done_after_wait: assert property (sync_done |-> $past(op_busy) && !clk_oe)
    else $error("done without wait");
  a_version_fixed: assert property (version_code == VERSION_CODE)
    else $error("version code wrong");
  a_bus_type_fixed: assert property (bus_type == BUS_TYPE)
    else $error("bus type wrong");
  a_first_bit: assert property (s_send |=> srq_oe && dat_oe == !$past(send_data[7]))
    else $error("first bit wrong");
  a_send_length: assert property (s_send |=> s_frame)
    else $error("send length wrong");
  a_send_rearms: assert property (s_send |-> ##[1:80] rx_armed)
    else $error("send did not rearm");
  a_enable_arms: assert property (fast_link_receive_enable |=> rx_armed)
    else $error("enable did not arm");
endmodule
bind dssfl_top dssfl_chk #(.VERSION_CODE(VERSION_CODE), .BUS_TYPE(BUS_TYPE)) i_chk (.*);

// [test/dssfl_host.sv]
/* host model: start acknowledge and fast-link byte sender.
   assumes open-drain lines with pull-ups resolved by the bench. */
`timescale 1ns/1ps
module dssfl_host (
  input wire logic clk_line,
  input wire logic send_go,
  input wire logic [7:0] tx_byte,
  output logic dat_oe,
  output logic srq_oe
);
  initial begin
    dat_oe = 1'b0;
    srq_oe = 1'b0;
  end
  // keyed on clk only, no os routines
  always @(negedge clk_line) begin
    #300 dat_oe = 1'b1;
    #200 dat_oe = 1'b0;
  end
  // msb first, 80 ns link clock
  always @(posedge send_go) begin
    for (int i = 7; i >= 0; i--) begin
      dat_oe = !tx_byte[i];
      srq_oe = 1'b1;
      #40 srq_oe = 1'b0;
      #40;
    end
    dat_oe = 1'b0;
  end
endmodule

// [test/dssfl_top_tb.sv]
/* bench for dssfl_top with the host model.
   assumes a 100 MHz clock. */
`timescale 1ns/1ps
module dssfl_top_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic done;
  logic [5:0] ops = '0;
  logic [7:0] send_data = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] got, rx_data, version_code;
  logic [3:0] bus_type;
  logic op_busy, sync_done, clk_oe, dat_oe, srq_oe, h_dat, h_srq, rx_valid, rx_armed;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  wire logic clk_in = !clk_oe;
  wire logic dat_in = !(dat_oe || h_dat);
  wire logic srq_in = !(srq_oe || h_srq);
  always #5 sys_clk = !sys_clk;
  dssfl_top #(.VERSION_CODE(8'h5a)) i_dssfl_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_low_dat_release_op(ops[0]), .wait_dat_low_op(ops[1]), .clk_release_op(ops[2]),
    .wait_dat_high_op(ops[3]), .fast_link_send_byte(ops[4]), .send_data(send_data),
    .fast_link_receive_enable(ops[5]), .op_busy(op_busy), .sync_done(sync_done),
    .version_code(version_code), .bus_type(bus_type), .clk_in(clk_in), .clk_out(),
    .clk_oe(clk_oe), .dat_in(dat_in), .dat_out(), .dat_oe(dat_oe), .srq_in(srq_in),
    .srq_out(), .srq_oe(srq_oe), .rx_data(rx_data), .rx_valid(rx_valid), .rx_armed(rx_armed));
  dssfl_host i_dssfl_host (.clk_line(clk_in), .send_go(go), .tx_byte(tx_byte),
    .dat_oe(h_dat), .srq_oe(h_srq));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task pulse(input logic [5:0] m);
    @(posedge sys_clk) #1 ops = m;
    @(posedge sys_clk) #1 ops = '0;
  endtask
  task settle;
    for (int k = 0; k < 200; k++) begin
      @(posedge sys_clk) #1 done |= sync_done;
      if (!op_busy && k > 2) break;
    end
  endtask
  task t_start;
    done = 1'b0;
    pulse(6'h01);
    check(clk_in, 1'b0);
    pulse(6'h02);
    check(op_busy, 1'b1);
    settle;
    pulse(6'h04);
    check(clk_in, 1'b1);
    pulse(6'h08);
    settle;
    check(done, 1'b1);
  endtask
  task t_send(input logic [7:0] b);
    send_data = b;
    pulse(6'h10);
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk);
      #1 got[i] = dat_in;
      repeat (4) @(posedge sys_clk);
    end
    check(got, b);
    settle;
  endtask
  task t_recv(input logic [7:0] b, input logic arm);
    if (arm) pulse(6'h20);
    check(rx_armed, 1'b1);
    tx_byte = b;
    go = 1'b1;
    for (int k = 0; k < 200 && !rx_valid; k++) @(posedge sys_clk) #1;
    check(rx_data, b);
    go = 1'b0;
  endtask
  task final_report;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    check(version_code, 8'h5a);
    check({4'h0, bus_type}, 8'h03);
    check({7'h00, (bus_type == 4'h3) || (bus_type == 4'h5)}, 8'h01);
    t_start;
    t_recv(8'h96, 1'b1);
    t_send(8'h3c);
    t_recv(8'ha5, 1'b0);
    final_report;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report;
    end
  end
endmodule
